// ==== hw/arts_defs.svh ====
// Constants for the auto-retry transmit sequencer
`ifndef ARTS_DEFS_SVH
`define ARTS_DEFS_SVH

// State control commands
`define ARTS_CMD_TX_START 5'h02
`define ARTS_CMD_OFF 5'h08
`define ARTS_CMD_SYNTH_ON 5'h09
`define ARTS_CMD_AACK_ON 5'h16
`define ARTS_CMD_RETRY_ON 5'h19

// State readback codes
`define ARTS_RB_OFF 5'h08
`define ARTS_RB_SYNTH_ON 5'h09
`define ARTS_RB_BUSY_AACK 5'h11
`define ARTS_RB_BUSY_RETRY 5'h12
`define ARTS_RB_AACK_ON 5'h16
`define ARTS_RB_RETRY_ON 5'h19

// Result codes
`define ARTS_RES_OK 3'h0
`define ARTS_RES_OK_PENDING 3'h1
`define ARTS_RES_CHAN_BUSY 3'h3
`define ARTS_RES_NO_ACK 3'h5
`define ARTS_RES_INVALID 3'h7

// Frame control field positions
`define ARTS_ACK_REQ_BIT 5
`define ARTS_PENDING_BIT 4
`define ARTS_FTYPE_ACK 3'h2

// CSMA limit value meaning no CSMA, single attempt
`define ARTS_CSMA_NONE 3'h7

// Timing: clock period and ACK wait (54 symbols)
`define ARTS_CLK_NS 100
`define ARTS_ACK_WAIT_NS 864000
`define ARTS_ACK_WAIT_CYC (`ARTS_ACK_WAIT_NS / `ARTS_CLK_NS)

`endif

// ==== hw/arts_pkg.sv ====
// Types shared by the auto-retry transmit sequencer
package arts_pkg;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_SYNTH = 4'h1,
    ST_RET_IDLE = 4'h2,
    ST_CCA_REQ = 4'h3,
    ST_CCA_WAIT = 4'h4,
    ST_FETCH = 4'h5,
    ST_LOAD = 4'h6,
    ST_SEND = 4'h7,
    ST_ACK_WAIT = 4'h8,
    ST_AACK_IDLE = 4'h9,
    ST_AACK_BUSY = 4'hA
  } seq_state_t;

endpackage : arts_pkg

// ==== hw/pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise
);
  logic s1; // First stage, read only by s2
  logic s2; // Second stage
  logic s3; // Third stage

  // Shift chain
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_level <= 1'b0;
      o_rise <= 1'b0;
    end else begin
      o_rise <= (s2 == s3) && s3 && !o_level;
      if (s2 == s3) begin
        o_level <= s3;
      end
    end
  end
endmodule : pin_sync
`default_nettype wire

// ==== hw/frame_ram.sv ====
// 128 x 8 frame buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module frame_ram (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [6:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [6:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:127]; // Storage

  // Host write port
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read port
  always_ff @(posedge i_clk) begin
    o_rdata <= mem[i_raddr];
  end
endmodule : frame_ram
`default_nettype wire

// ==== hw/auto_retry_transmit_sequencer.sv ====
// Auto-retry transmit sequencer with auto-ack receive reporting
//
// How it works
// RULE1 - CSMA-CA first, send only on idle
// RULE2 - Transaction end only after all retries
// RULE3 - Host configures while off or synthesizer-on
// RULE4 - Host loads whole PSDU before start
// RULE5 - Start on pin rise or start command
// RULE6 - Busy past CSMA limit: abort, code 3
// RULE7 - First PSDU octet bit 5 asks ACK
// RULE8 - Wait for ACK, read its pending bit
// RULE9 - ACK reception never writes frame buffer
// RULE10 - Other frames during ACK wait discarded
// RULE11 - No ACK in 864 us: retry, code 5
// RULE12 - Codes 0,1,3,5,7 as documented
// RULE13 - Entering mode sets result code 7
// RULE14 - No ACK requested: end after send, success
// RULE15 - CSMA limit 7: no CSMA, one attempt
// RULE16 - Busy readback during transaction, then idle
// RULE17 - ACK pending bit gives code 1
// RULE18 - Host unmasks wanted interrupts itself
// RULE19 - Receive mode: PHR and match interrupts
// RULE20 - Receive end only when matched, FCS good
// RULE21 - Mode entry from off: lock interrupt
// RULE22 - Start or match without end allowed
// RULE23 - ACK frames raise no match, no end
// RULE24 - Clear retry counters on every start
`timescale 1ns/1ps
`default_nettype none
`include "arts_defs.svh"
module auto_retry_transmit_sequencer #(
  parameter int ACK_WAIT_CYCLES = `ARTS_ACK_WAIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sleep_transmit_pin,
  input wire logic i_state_control_reg_we,
  input wire logic [4:0] i_state_control_reg,
  input wire logic [2:0] i_csma_retry_limit,
  input wire logic [3:0] i_frame_retry_limit,
  input wire logic i_fb_we,
  input wire logic [6:0] i_fb_addr,
  input wire logic [7:0] i_fb_wdata,
  input wire logic i_cca_done,
  input wire logic i_cca_idle,
  input wire logic i_tx_ready,
  input wire logic i_rx_phr,
  input wire logic i_rx_addr_match,
  input wire logic i_rx_frame_done,
  input wire logic i_rx_fcs_ok,
  input wire logic [7:0] i_rx_fcf,
  output logic o_cca_req,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_last,
  output logic [4:0] o_state_readback,
  output logic [2:0] o_result_code,
  output logic o_transaction_end_irq,
  output logic o_address_match_irq,
  output logic o_rx_start_irq,
  output logic o_pll_lock_irq
);
  import arts_pkg::*;

  seq_state_t state; // Current state
  seq_state_t next_state; // Next state
  logic pin_rise; // Synchronised pin rising edge
  logic [7:0] rd_data; // Frame buffer read data
  logic [6:0] ptr; // Frame buffer byte pointer
  logic [6:0] len; // Frame length from PHR
  logic ack_req; // Frame asks for ACK
  logic [2:0] csma_cnt; // CSMA retries used
  logic [3:0] frame_cnt; // Frame retries used
  logic [13:0] timer; // ACK wait timer
  logic matched; // Receive frame passed filter
  logic cmd_go; // Start command written
  logic start_evt; // Transaction start
  logic no_csma; // Slotted single-shot mode
  logic cca_busy; // CCA answered busy
  logic csma_spent; // CSMA retries exhausted
  logic cca_fail; // Channel_busy_fail
  logic send_done; // Last byte accepted
  logic ack_ok; // Valid ACK received
  logic ack_tmo; // ACK wait expired
  logic frames_spent; // No frame retry left
  logic is_ack_frame; // Received frame is ACK type
  logic cmd_mode; // Mode change allowed

  // Pin synchroniser
  pin_sync u_pin_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pin(i_sleep_transmit_pin),
    .o_level(),
    .o_rise(pin_rise)
  );

  // Frame buffer; only the host port writes it
  // RULE9 - transmit data kept
  frame_ram u_frame_ram (
    .i_clk(i_clk),
    .i_we(i_fb_we),
    .i_waddr(i_fb_addr),
    .i_wdata(i_fb_wdata),
    .i_raddr(ptr),
    .o_rdata(rd_data)
  );

  // Event decode
  assign cmd_go = i_state_control_reg_we &&
                  (i_state_control_reg == `ARTS_CMD_TX_START);
  // RULE5 - pin or command start
  assign start_evt = (state == ST_RET_IDLE) && (cmd_go || pin_rise);
  // RULE15 - limit 7 means single shot
  assign no_csma = (i_csma_retry_limit == `ARTS_CSMA_NONE);
  assign cca_busy = (state == ST_CCA_WAIT) && i_cca_done && !i_cca_idle;
  assign csma_spent = (csma_cnt == i_csma_retry_limit);
  // RULE6 - busy past limit
  assign cca_fail = cca_busy && csma_spent;
  assign send_done = (state == ST_SEND) && i_tx_ready && (ptr == len);
  assign is_ack_frame = (i_rx_fcf[2:0] == `ARTS_FTYPE_ACK);
  // RULE10 - only valid ACK counts
  assign ack_ok = (state == ST_ACK_WAIT) && i_rx_frame_done &&
                  i_rx_fcs_ok && is_ack_frame;
  // RULE11 - ACK wait timeout
  assign ack_tmo = (state == ST_ACK_WAIT) && !ack_ok &&
                   (timer == 14'(ACK_WAIT_CYCLES - 1));
  // RULE15 - frame retry limit ignored
  assign frames_spent = no_csma || (frame_cnt == i_frame_retry_limit);
  assign cmd_mode = i_state_control_reg_we &&
                    ((state == ST_OFF) || (state == ST_SYNTH) ||
                     (state == ST_RET_IDLE) || (state == ST_AACK_IDLE));

  // Next state
  always_comb begin
    next_state = state;
    if (cmd_mode && (i_state_control_reg == `ARTS_CMD_OFF)) begin
      next_state = ST_OFF;
    end else if (cmd_mode &&
                 (i_state_control_reg == `ARTS_CMD_SYNTH_ON)) begin
      next_state = ST_SYNTH;
    end else if (cmd_mode &&
                 (i_state_control_reg == `ARTS_CMD_RETRY_ON)) begin
      next_state = ST_RET_IDLE;
    end else if (cmd_mode &&
                 (i_state_control_reg == `ARTS_CMD_AACK_ON)) begin
      next_state = ST_AACK_IDLE;
    end else begin
      unique case (state)
        ST_OFF, ST_SYNTH: begin
          next_state = state;
        end
        ST_RET_IDLE: begin
          // RULE1 - CSMA before sending
          if (start_evt) begin
            next_state = no_csma ? ST_FETCH : ST_CCA_REQ;
          end
        end
        ST_CCA_REQ: begin
          next_state = ST_CCA_WAIT;
        end
        ST_CCA_WAIT: begin
          // Idle channel sends, busy retries or aborts
          if (i_cca_done && i_cca_idle) begin
            next_state = ST_FETCH;
          end else if (cca_busy) begin
            next_state = csma_spent ? ST_RET_IDLE : ST_CCA_REQ;
          end
        end
        ST_FETCH: begin
          next_state = ST_LOAD;
        end
        ST_LOAD: begin
          next_state = ST_SEND;
        end
        ST_SEND: begin
          // RULE8 - go receive for ACK
          if (send_done) begin
            next_state = ack_req ? ST_ACK_WAIT : ST_RET_IDLE;
          end else if (i_tx_ready) begin
            next_state = ST_FETCH;
          end
        end
        ST_ACK_WAIT: begin
          // RULE11 - whole transaction repeats
          if (ack_ok) begin
            next_state = ST_RET_IDLE;
          end else if (ack_tmo) begin
            next_state = frames_spent ? ST_RET_IDLE
                       : (no_csma ? ST_FETCH : ST_CCA_REQ);
          end
        end
        ST_AACK_IDLE: begin
          if (i_rx_phr) begin
            next_state = ST_AACK_BUSY;
          end
        end
        ST_AACK_BUSY: begin
          if (i_rx_frame_done) begin
            next_state = ST_AACK_IDLE;
          end
        end
        default: begin
          next_state = ST_OFF;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // State readback follows the next state
  // RULE16 - busy for whole transaction
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_state_readback <= `ARTS_RB_OFF;
    end else begin
      unique case (next_state)
        ST_OFF: o_state_readback <= `ARTS_RB_OFF;
        ST_SYNTH: o_state_readback <= `ARTS_RB_SYNTH_ON;
        ST_RET_IDLE: o_state_readback <= `ARTS_RB_RETRY_ON;
        ST_AACK_IDLE: o_state_readback <= `ARTS_RB_AACK_ON;
        ST_AACK_BUSY: o_state_readback <= `ARTS_RB_BUSY_AACK;
        default: o_state_readback <= `ARTS_RB_BUSY_RETRY;
      endcase
    end
  end

  // Retry counters
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      csma_cnt <= 3'h0;
      frame_cnt <= 4'h0;
    end else if (start_evt) begin
      // RULE24 - fresh counters per start
      csma_cnt <= 3'h0;
      frame_cnt <= 4'h0;
    end else if (cca_busy && !csma_spent) begin
      // RULE6 - count CSMA retry
      csma_cnt <= csma_cnt + 3'h1;
    end else if (ack_tmo && !frames_spent) begin
      // New attempt restarts CSMA count
      csma_cnt <= 3'h0;
      frame_cnt <= frame_cnt + 4'h1;
    end
  end

  // ACK wait timer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      timer <= 14'h0000;
    end else if (state == ST_ACK_WAIT) begin
      timer <= timer + 14'h0001;
    end else begin
      timer <= 14'h0000;
    end
  end

  // CCA request pulse, one cycle per attempt
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cca_req <= 1'b0;
    end else begin
      o_cca_req <= (next_state == ST_CCA_REQ);
    end
  end

  // Transmit byte pointer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ptr <= 7'h00;
    end else if ((state == ST_SEND) && i_tx_ready) begin
      ptr <= send_done ? 7'h00 : ptr + 7'h01;
    end else if ((state != ST_FETCH) && (state != ST_LOAD) &&
                 (state != ST_SEND)) begin
      ptr <= 7'h00;
    end
  end

  // Transmit stream: PHR at byte 0, then PSDU
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h00;
      o_tx_last <= 1'b0;
      len <= 7'h00;
      ack_req <= 1'b0;
    end else if (state == ST_LOAD) begin
      o_tx_valid <= 1'b1;
      o_tx_data <= rd_data;
      if (ptr == 7'h00) begin
        len <= rd_data[6:0];
        o_tx_last <= (rd_data[6:0] == 7'h00);
      end else begin
        o_tx_last <= (ptr == len);
      end
      // RULE7 - ACK request bit
      if (ptr == 7'h01) begin
        ack_req <= rd_data[`ARTS_ACK_REQ_BIT];
      end
    end else if ((state == ST_SEND) && i_tx_ready) begin
      o_tx_valid <= 1'b0;
      o_tx_last <= 1'b0;
    end
  end

  // Result code
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_result_code <= `ARTS_RES_OK;
    end else if ((cmd_mode &&
                 ((i_state_control_reg == `ARTS_CMD_RETRY_ON) ||
                  (i_state_control_reg == `ARTS_CMD_AACK_ON))) ||
                 start_evt) begin
      // RULE13 - invalid until finished
      o_result_code <= `ARTS_RES_INVALID;
    end else if (cca_fail) begin
      // RULE12 - channel busy failure
      o_result_code <= `ARTS_RES_CHAN_BUSY;
    end else if (send_done && !ack_req) begin
      // RULE14 - sent without ACK request
      o_result_code <= `ARTS_RES_OK;
    end else if (ack_ok) begin
      // RULE17 - pending bit selects code
      o_result_code <= i_rx_fcf[`ARTS_PENDING_BIT] ?
                       `ARTS_RES_OK_PENDING : `ARTS_RES_OK;
    end else if (ack_tmo && frames_spent) begin
      // RULE11 - retries exhausted
      o_result_code <= `ARTS_RES_NO_ACK;
    end
  end

  // Receive filter memory for the current frame
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      matched <= 1'b0;
    end else if (state != ST_AACK_BUSY) begin
      matched <= 1'b0;
    end else if (i_rx_addr_match && !is_ack_frame) begin
      matched <= 1'b1;
    end
  end

  // Interrupt pulses
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_transaction_end_irq <= 1'b0;
      o_address_match_irq <= 1'b0;
      o_rx_start_irq <= 1'b0;
      o_pll_lock_irq <= 1'b0;
    end else begin
      // RULE2 - end only at final outcome
      // RULE20 - receive end needs match and FCS
      // RULE22 - failed FCS gives no end
      o_transaction_end_irq <= cca_fail || (send_done && !ack_req) ||
                               ack_ok || (ack_tmo && frames_spent) ||
                               ((state == ST_AACK_BUSY) &&
                                i_rx_frame_done && i_rx_fcs_ok &&
                                (matched || (i_rx_addr_match &&
                                             !is_ack_frame)));
      // RULE19 - match interrupt once per frame
      // RULE23 - ACK frames never raise the match interrupt
      o_address_match_irq <= (state == ST_AACK_BUSY) && !matched &&
                             i_rx_addr_match && !is_ack_frame;
      // RULE19 - PHR interrupt
      o_rx_start_irq <= (state == ST_AACK_IDLE) && i_rx_phr &&
                        !cmd_mode;
      // RULE21 - lock on entry from off
      o_pll_lock_irq <= cmd_mode && (state == ST_OFF) &&
                        ((i_state_control_reg == `ARTS_CMD_RETRY_ON) ||
                         (i_state_control_reg == `ARTS_CMD_AACK_ON));
    end
  end
endmodule : auto_retry_transmit_sequencer
`default_nettype wire

// ==== sim/arts_seq_sva.sv ====
// Port checker for the auto-retry transmit sequencer
`timescale 1ns/1ps
`default_nettype none
module arts_seq_sva #(
  parameter int ACK_WAIT_CYCLES = 40
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_state_control_reg_we,
  input wire logic [4:0] i_state_control_reg,
  input wire logic i_cca_done,
  input wire logic i_cca_idle,
  input wire logic i_tx_ready,
  input wire logic i_rx_phr,
  input wire logic i_rx_frame_done,
  input wire logic i_rx_fcs_ok,
  input wire logic [7:0] i_rx_fcf,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic [4:0] o_state_readback,
  input wire logic [2:0] o_result_code,
  input wire logic o_transaction_end_irq,
  input wire logic o_rx_start_irq,
  input wire logic o_pll_lock_irq
);
  logic [4:0] rb; // Short view of the readback
  logic [2:0] ft; // Frame type of the received frame
  logic wr; // Command write strobe
  assign rb = o_state_readback;
  assign ft = i_rx_fcf[2:0];
  assign wr = i_state_control_reg_we;
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  AST_ENTRY: assert property (wr && rb == 5'h08 && (i_state_control_reg ==
    5'h19 || i_state_control_reg == 5'h16) |=> o_pll_lock_irq &&
    o_result_code == 3'h7 && rb == $past(i_state_control_reg))
    else $error("mode entry wrong");
  AST_START: assert property (wr && i_state_control_reg == 5'h02 &&
    rb == 5'h19 |=> rb == 5'h12 && o_result_code == 3'h7)
    else $error("start command not taken");
  AST_CCA_GO: assert property (i_cca_done && i_cca_idle && rb == 5'h12
    |-> ##3 o_tx_valid) else $error("no send after idle channel");
  AST_HOLD: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid &&
    $stable(o_tx_data)) else $error("byte dropped while stalled");
  AST_BUSY: assert property (o_tx_valid |-> rb == 5'h12)
    else $error("sending while not busy");
  AST_ACK_OK: assert property (i_rx_frame_done && i_rx_fcs_ok && ft == 3'h2
    && rb == 5'h12 |=> o_transaction_end_irq &&
    o_result_code == {2'b00, $past(i_rx_fcf[4])}) else $error("ack ignored");
  AST_DISCARD: assert property (i_rx_frame_done && ft != 3'h2 &&
    rb == 5'h12 |=> !o_transaction_end_irq) else $error("frame not dropped");
  AST_RX_START: assert property (i_rx_phr && rb == 5'h16 |=>
    o_rx_start_irq && rb == 5'h11) else $error("no receive start");
  AST_ACK_SILENT: assert property (i_rx_frame_done && ft == 3'h2 &&
    rb == 5'h11 |=> !o_transaction_end_irq) else $error("ack frame ended");
  AST_BAD_FCS: assert property (i_rx_frame_done && !i_rx_fcs_ok &&
    rb == 5'h11 |=> !o_transaction_end_irq) else $error("bad frame ended");
  // Main outcomes
  cover property (o_transaction_end_irq && o_result_code == 3'h3);
  cover property (o_transaction_end_irq && o_result_code == 3'h5);
  cover property (o_transaction_end_irq && o_result_code == 3'h1);
endmodule : arts_seq_sva
bind auto_retry_transmit_sequencer arts_seq_sva #(
  .ACK_WAIT_CYCLES(ACK_WAIT_CYCLES)
) arts_seq_sva_inst (.i_clk, .i_rst, .i_state_control_reg_we,
  .i_state_control_reg, .i_cca_done, .i_cca_idle, .i_tx_ready, .i_rx_phr,
  .i_rx_frame_done, .i_rx_fcs_ok, .i_rx_fcf, .o_tx_valid, .o_tx_data,
  .o_state_readback, .o_result_code, .o_transaction_end_irq,
  .o_rx_start_irq, .o_pll_lock_irq);
`default_nettype wire

// ==== sim/arts_radio_model.sv ====
// Radio side model: CCA answers, byte sink, frame source
`timescale 1ns/1ps
`default_nettype none
module arts_radio_model (
  input wire logic i_clk,
  input wire logic i_cca_req,
  input wire logic i_tx_valid,
  input wire logic i_tx_last,
  output logic o_cca_done,
  output logic o_cca_idle,
  output logic o_tx_ready,
  output logic o_rx_phr,
  output logic o_rx_addr_match,
  output logic o_rx_frame_done,
  output logic o_rx_fcs_ok,
  output logic [7:0] o_rx_fcf
);
  int busy_left = 0; // Busy answers still to give
  int ack_kind = 0; // 0 silent, 1 ack, 2 ack with pending
  int cca_wait = -1; // Cycles to the next answer
  logic acc_last = 1'b0; // Last byte taken at this edge
  initial begin
    {o_cca_done, o_cca_idle, o_tx_ready, o_rx_phr} = 4'h0;
    {o_rx_addr_match, o_rx_frame_done, o_rx_fcs_ok} = 3'h0;
    o_rx_fcf = 8'h00;
  end
  // One frame; fields go to their inverse outside their strobe
  task automatic send_frame(input logic [7:0] fcf, input logic fcs);
    @(negedge i_clk) o_rx_phr = 1'b1;
    @(negedge i_clk) o_rx_phr = 1'b0;
    @(negedge i_clk) o_rx_fcf = fcf;
    o_rx_addr_match = 1'b1;
    @(negedge i_clk) o_rx_addr_match = 1'b0;
    o_rx_fcf = ~fcf;
    @(negedge i_clk) o_rx_fcf = fcf;
    o_rx_frame_done = 1'b1;
    o_rx_fcs_ok = fcs;
    @(negedge i_clk) o_rx_frame_done = 1'b0;
    o_rx_fcf = ~fcf;
    o_rx_fcs_ok = ~fcs;
  endtask : send_frame
  // A stray data frame, then the ack
  task automatic reply();
    send_frame(8'h41, 1'b1);
    send_frame({3'h0, ack_kind == 2, 4'h2}, 1'b1);
  endtask : reply
  always @(posedge i_clk) acc_last <= i_tx_valid && o_tx_ready && i_tx_last;
  // Random stalls and delayed channel answers
  always @(negedge i_clk) begin
    o_cca_done <= 1'b0;
    o_cca_idle <= ~o_cca_idle;
    o_tx_ready <= ($urandom % 3) != 0;
    if (i_cca_req) begin
      cca_wait <= 2 + $urandom % 4;
    end else if (cca_wait > 0) begin
      cca_wait <= cca_wait - 1;
    end else if (cca_wait == 0) begin
      cca_wait <= -1;
      o_cca_done <= 1'b1;
      o_cca_idle <= busy_left == 0;
      busy_left <= busy_left > 0 ? busy_left - 1 : 0;
    end
    if (acc_last && ack_kind != 0) fork
      reply();
    join_none
  end
endmodule : arts_radio_model
`default_nettype wire

// ==== sim/test_auto_retry_transmit_sequencer.sv ====
// Bench for the auto-retry transmit sequencer
`timescale 1ns/1ps
`default_nettype none
module test_auto_retry_transmit_sequencer;
  logic i_clk = 0, i_rst = 1, pin = 0, we = 0, fb_we = 0, ack_req = 0;
  logic [4:0] cmd = 0, rb;
  logic [2:0] csma = 0, res;
  logic [3:0] flim = 0;
  logic [6:0] fb_addr = 0;
  logic [7:0] fb_data = 0, tx_data, fcf;
  logic cca_req, cca_done, cca_idle, tx_ready, tx_valid, tx_last;
  logic phr, match, fdone, fcs_ok, end_irq, address_match_irq, rxs, lock;
  logic [7:0] fb [0:127]; // Copy of the frame buffer
  int bad_count = 0, n_compared = 0, cyc = 0, idx = 0, last_at = 0;
  int n_cca = 0, n_att = 0, n_end = 0, n_ami = 0, n_rxs = 0;
  always #50 i_clk = ~i_clk;
  auto_retry_transmit_sequencer #(.ACK_WAIT_CYCLES(40))
    auto_retry_transmit_sequencer_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_sleep_transmit_pin(pin), .i_state_control_reg_we(we),
    .i_state_control_reg(cmd), .i_csma_retry_limit(csma),
    .i_frame_retry_limit(flim), .i_fb_we(fb_we), .i_fb_addr(fb_addr),
    .i_fb_wdata(fb_data), .i_cca_done(cca_done), .i_cca_idle(cca_idle),
    .i_tx_ready(tx_ready), .i_rx_phr(phr), .i_rx_addr_match(match),
    .i_rx_frame_done(fdone), .i_rx_fcs_ok(fcs_ok), .i_rx_fcf(fcf),
    .o_cca_req(cca_req), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .o_tx_last(tx_last), .o_state_readback(rb), .o_result_code(res),
    .o_transaction_end_irq(end_irq), .o_address_match_irq(address_match_irq),
    .o_rx_start_irq(rxs), .o_pll_lock_irq(lock));
  arts_radio_model arts_radio_model_inst (.i_clk(i_clk), .i_cca_req(cca_req),
    .i_tx_valid(tx_valid), .i_tx_last(tx_last), .o_cca_done(cca_done),
    .o_cca_idle(cca_idle), .o_tx_ready(tx_ready), .o_rx_phr(phr),
    .o_rx_addr_match(match), .o_rx_frame_done(fdone), .o_rx_fcs_ok(fcs_ok),
    .o_rx_fcf(fcf));
  task automatic results();
    $display("TB: %0d compared, %0d bad", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Counters and end-timing check, settled at the falling edge
  always @(negedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      results();
    end
    n_cca <= n_cca + int'(cca_req);
    n_end <= n_end + int'(end_irq);
    n_ami <= n_ami + int'(address_match_irq);
    n_rxs <= n_rxs + int'(rxs);
    if (end_irq && !ack_req && res == 3'h0)
      check(8'(cyc - last_at <= 2), 8'h01);
  end
  // Byte handshake, seen with the values the design samples
  always @(posedge i_clk) begin
    if (tx_valid && tx_ready) begin
      check(tx_data, fb[idx]);
      idx <= tx_last ? 0 : idx + 1;
      n_att <= n_att + int'(tx_last);
      if (tx_last) last_at <= cyc;
    end
  end
  task automatic command(input logic [4:0] c);
    @(negedge i_clk) cmd = c;
    we = 1;
    @(negedge i_clk) we = 0;
  endtask : command
  task automatic load_frame(input int len, input logic ackr);
    for (int a = 0; a <= len; a++) begin
      fb[a] = (a == 0) ? 8'(len) : 8'($urandom);
      if (a == 1) fb[a][5] = ackr;
      @(negedge i_clk) fb_we = 1;
      fb_addr = 7'(a);
      fb_data = fb[a];
    end
    @(negedge i_clk) fb_we = 0;
    ack_req = ackr;
  endtask : load_frame
  function automatic logic [2:0] exp_code(input int busy, input int kind);
    if (csma != 7 && busy > csma) return 3'h3;
    if (!ack_req) return 3'h0;
    return kind == 2 ? 3'h1 : kind == 1 ? 3'h0 : 3'h5;
  endfunction : exp_code
  // One transaction, then code, attempts and channel checks
  task automatic transact(input int busy, input int kind, input logic by_pin);
    int e0, a0, c0, att;
    logic [2:0] code;
    e0 = n_end;
    a0 = n_att;
    c0 = n_cca;
    code = exp_code(busy, kind);
    att = code == 3'h3 ? 0 : (code == 3'h5 && csma != 7) ? flim + 1 : 1;
    arts_radio_model_inst.busy_left = busy;
    arts_radio_model_inst.ack_kind = ack_req ? kind : 0;
    if (by_pin) begin
      @(negedge i_clk) pin = 1;
    end else begin
      command(5'h02);
      check(rb, 5'h12);
    end
    while (n_end == e0) @(negedge i_clk);
    pin = 0;
    check(res, code);
    check(rb, 5'h19);
    check(8'(n_att - a0), 8'(att));
    check(8'(n_cca - c0), csma == 7 ? 0 : code == 3'h3 ? csma + 1 :
      busy + att);
    repeat (4) @(negedge i_clk);
    check(8'(n_end - e0), 8'h01);
  endtask : transact
  initial begin
    int busy, e, a, s;
    void'($urandom(32'hA0C6));
    repeat (4) @(negedge i_clk);
    i_rst = 0;
    check(rb, 5'h08);
    check(res, 3'h0);
    for (int t = 0; t < 24; t++) begin
      if (t % 2 == 0) begin
        command(5'h08);
        csma = t < 16 ? 3'(t / 2) : 3'($urandom);
        flim = 4'($urandom % 3);
        command(5'h19);
        check(lock, 1);
        check(res, 3'h7);
      end
      busy = csma == 7 ? 0 : t % 4 == 1 ? csma + 1 : $urandom % (csma + 1);
      load_frame(3 + $urandom % 12, 1'($urandom));
      transact(busy, $urandom % 3, 1'($urandom));
    end
    command(5'h08);
    command(5'h16);
    check(rb, 5'h16);
    check(lock, 1);
    e = n_end;
    a = n_ami;
    s = n_rxs;
    arts_radio_model_inst.send_frame(8'h41, 1'b1);
    arts_radio_model_inst.send_frame(8'h41, 1'b0);
    arts_radio_model_inst.send_frame(8'h02, 1'b1);
    repeat (3) @(negedge i_clk);
    check(8'(n_rxs - s), 8'h03);
    check(8'(n_ami - a), 8'h02);
    check(8'(n_end - e), 8'h01);
    results();
  end
endmodule : test_auto_retry_transmit_sequencer
`default_nettype wire
